// *** src/pwr_mgr_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite register words at byte offsets
// Notes:   Definitions only
`ifndef PWR_MGR_PARAMS_SVH
`define PWR_MGR_PARAMS_SVH

`define CLK_PERIOD_NS       25
`define USBREG_SETTLE_NS    1000
`define USBREG_SETTLE_CYC   (`USBREG_SETTLE_NS / `CLK_PERIOD_NS)

`define OFS_TASK_FIXLAT     12'h078
`define OFS_TASK_ECONOMY    12'h07c
`define OFS_EV_VBUS_DET     12'h11c
`define OFS_EV_VBUS_REM     12'h120
`define OFS_EV_USB_RDY      12'h124
`define OFS_RESET_CAUSE     12'h400
`define OFS_USB_STATUS      12'h438
`define OFS_DEEP_OFF        12'h500
`define OFS_MODE_STATUS     12'h600
`define OFS_USB_ENABLE      12'h604
`define OFS_PIN_SEL0        12'h608
`define OFS_PIN_SEL1        12'h60c
`define OFS_RAM_BASE        12'h900
`define RAM_STRIDE_SHIFT    4

`define CAUSE_PIN           0
`define CAUSE_WDOG          1
`define CAUSE_SOFT          2
`define CAUSE_LOCKUP        3
`define CAUSE_GPIO          16
`define CAUSE_COMP          17
`define CAUSE_DEBUG         18
`define CAUSE_FIELD         19
`define CAUSE_VBUS          20

`define RAM_PWR_RESET       2'h1
`define PIN_SEL_RESET       32'hffff_ffff
`define PIN_SEL_CONNECT_BIT 31

`endif

// *** src/pwr_mgr_pkg.sv ***
// Purpose: Types for the power mode and reset manager
// Assumes: Constants live in pwr_mgr_params.svh
// Notes:   Reset target vector is carried as one packed struct
package pwr_mgr_pkg;

  typedef enum logic [1:0] {
    ST_ON      = 2'b00,
    ST_OFF     = 2'b01,
    ST_EMU_OFF = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic gpio;
    logic debug;
    logic swd_port;
    logic ram;
    logic wdog;
    logic retained;
    logic cause;
  } rst_targets_t;

  typedef struct packed {
    logic gpio_wake;
    logic comp_wake;
    logic field_wake;
  } wake_sigs_t;

endpackage

// *** src/power_mode_reset_manager.sv ***
// Purpose: Power states, sub-modes, RAM section control, reset routing
// Assumes: Supervisor, watchdog and pin levels arrive synchronous to CLK
// Notes:   Registers behind an AHB-Lite slave with zero wait states
//
// Summary of operation
// R01: Events on bus supply rise and fall
// R02: Bus supply wakes deep-off, flags cause
// R03: Regulator on, ready after settle time
// R04: Deep-off write powers core down, stops tasks
// R05: Wake on gpio, comparator, field, vbus, reset
// R06: Every deep-off wakeup is a system reset
// R07: Software drains memory transfers before deep-off
// R08: Debug mode only emulates deep-off
// R09: Power-on gives on state, low-power sub-mode
// R10: Fixed-latency task selects fixed-latency sub-mode
// R11: Economy task selects low-power sub-mode
// R12: Deep-off: RAM inaccessible, held if hold on
// R13: On state: power field gives access, retention
// R14: RAM power registers survive deep-off
// R15: Power-on holds reset until supply ready
// R16: Reset pin gives pin reset via selects
// R17: Core request or debug port soft reset
// R18: Brownout places system in reset
// R19: Lockup, soft, wakeup reset their targets
// R20: Watchdog, pin, brownout, power-on targets
// R21: RAM contents never cleared by reset
// R22: Watchdog timeout gives watchdog reset
// R23: Cause flags accumulate, cleared by writing one
`timescale 1ns/1ps
`include "pwr_mgr_params.svh"

module power_mode_reset_manager
  import pwr_mgr_pkg::*;
#(
  parameter int RAM_SECTIONS = 9,
  parameter int SETTLE_CYC   = `USBREG_SETTLE_CYC
) (
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  input  wire logic                    HSEL,
  input  wire logic [31:0]             HADDR,
  input  wire logic [1:0]              HTRANS,
  input  wire logic                    HWRITE,
  input  wire logic [2:0]              HSIZE,
  input  wire logic [31:0]             HWDATA,
  input  wire logic                    HREADY,
  output logic      [31:0]             HRDATA,
  output logic                         HREADYOUT,
  output logic                         HRESP,
  input  wire logic                    VBUS_VALID,
  input  wire logic                    SUPPLY_OK,
  input  wire logic                    REGS_STARTED,
  input  wire logic                    BROWNOUT,
  input  wire logic                    RESET_PIN_N,
  input  wire logic                    CORE_RESET_REQ,
  input  wire logic                    DEBUG_PORT_RESET,
  input  wire logic                    CORE_LOCKUP,
  input  wire logic                    WATCHDOG_TIMEOUT,
  input  wire logic                    DEBUG_MODE,
  input  wire wake_sigs_t              WAKE,
  output rst_targets_t                 RST_OUT,
  output logic                         CORE_POWER_ON,
  output logic                         TASK_ABORT,
  output logic                         FIXED_LATENCY,
  output logic                         USB_REG_ON,
  output logic                         VBUS_DETECTED_EVENT,
  output logic                         VBUS_REMOVED_EVENT,
  output logic                         USB_SUPPLY_READY_EVENT,
  output logic      [RAM_SECTIONS-1:0] RAM_ACCESS,
  output logic      [RAM_SECTIONS-1:0] RAM_RETAIN
);

  // Elaboration checks: the section index is four bits, the settle counter sixteen
  if (RAM_SECTIONS < 1 || RAM_SECTIONS > 16) begin : g_bad_sections
    $error("RAM_SECTIONS out of range");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  // All checks below share one clock and the synchronous reset
  default clocking cb_main @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // Bus address phase capture; single-cycle data phase, always OKAY
  logic        wr_pend_q;
  logic [11:0] addr_q;
  wire         acc     = HSEL && HREADY && HTRANS[1];
  wire         wr      = wr_pend_q;
  // Reads decode the live address so data stands through the data phase
  wire  [11:0] rd_addr = HADDR[11:0];
  wire         rd_ram  = (rd_addr[11:8] == `OFS_RAM_BASE >> 8) && (rd_addr[3:0] == 4'h0);
  wire  [3:0]  rd_idx  = rd_addr[7:4];
  wire         is_ram  = (addr_q[11:8] == `OFS_RAM_BASE >> 8) && (addr_q[3:0] == 4'h0);
  wire  [3:0]  ram_idx = addr_q[7:4];
  wire         w_fix   = wr && addr_q == `OFS_TASK_FIXLAT && HWDATA[0];
  wire         w_eco   = wr && addr_q == `OFS_TASK_ECONOMY && HWDATA[0];
  wire         w_off   = wr && addr_q == `OFS_DEEP_OFF && HWDATA[0];
  wire         w_cause = wr && addr_q == `OFS_RESET_CAUSE;

  // Reset sources, decoded from level inputs
  pwr_state_t  state_q;
  logic        vbus_q, usb_en_q, rdy_q, pin_hold_q;
  logic [31:0] pin_sel0_q, pin_sel1_q, cause_q;
  logic [15:0] settle_q;
  logic [1:0]  ram_pwr_q [RAM_SECTIONS];
  wire  pin_en   = !pin_sel0_q[`PIN_SEL_CONNECT_BIT] && !pin_sel1_q[`PIN_SEL_CONNECT_BIT];
  wire  por      = !SUPPLY_OK || !REGS_STARTED;                          // R15
  wire  bor      = BROWNOUT;                                             // R18
  wire  pin_rst  = pin_en && !RESET_PIN_N;                               // R16
  wire  soft_rst = CORE_RESET_REQ || DEBUG_PORT_RESET;                   // R17
  wire  lock_rst = CORE_LOCKUP && !DEBUG_MODE && state_q == ST_ON;
  wire  wdog_rst = WATCHDOG_TIMEOUT && state_q == ST_ON;                 // R22
  wire  in_off   = state_q != ST_ON;
  wire  vbus_rise = VBUS_VALID && !vbus_q;
  wire  any_wake = in_off && (WAKE.gpio_wake || WAKE.comp_wake ||
                              WAKE.field_wake || vbus_rise);             // R05
  wire  hard     = por || bor;
  wire  full     = pin_rst || wdog_rst;

  // Target vector per source; RAM target never clears contents
  rst_targets_t tgt_d;
  assign tgt_d.cpu      = hard || full || soft_rst || lock_rst || any_wake;  // R06
  assign tgt_d.periph   = tgt_d.cpu;                                     // R19
  assign tgt_d.gpio     = hard || full || soft_rst || lock_rst;          // R19
  assign tgt_d.debug    = hard || full || (any_wake && !DEBUG_MODE);     // R19
  assign tgt_d.swd_port = hard;                                          // R20
  assign tgt_d.ram      = hard || full || any_wake;                      // R21
  assign tgt_d.wdog     = hard || full || any_wake;                      // R20
  assign tgt_d.retained = hard || full;                                  // R20
  assign tgt_d.cause    = hard;                                          // R20

  // Cause flags set by source, cleared by write-one; set wins
  logic [31:0] cause_set;
  always_comb begin
    cause_set = 32'h0;
    cause_set[`CAUSE_PIN]    = pin_rst;
    cause_set[`CAUSE_WDOG]   = wdog_rst;
    cause_set[`CAUSE_SOFT]   = soft_rst;
    cause_set[`CAUSE_LOCKUP] = lock_rst;
    cause_set[`CAUSE_GPIO]   = in_off && WAKE.gpio_wake;
    cause_set[`CAUSE_COMP]   = in_off && WAKE.comp_wake;
    cause_set[`CAUSE_DEBUG]  = in_off && DEBUG_MODE && any_wake;
    cause_set[`CAUSE_FIELD]  = in_off && WAKE.field_wake;
    cause_set[`CAUSE_VBUS]   = in_off && vbus_rise;                      // R02
  end
  wire [31:0] cause_clr = w_cause ? HWDATA : 32'h0;
  wire [31:0] cause_d   = hard ? 32'h0 : (cause_q & ~cause_clr) | cause_set;  // R23

  // Power state: any reset from deep-off lands in on state
  pwr_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ON:      if (w_off) begin
        state_d = DEBUG_MODE ? ST_EMU_OFF : ST_OFF;                      // R08
      end
      ST_OFF, ST_EMU_OFF: if (tgt_d.cpu) begin
        state_d = ST_ON;                                                 // R02
      end
      default:    state_d = ST_ON;
    endcase
    if (hard) state_d = ST_ON;                                           // R09
  end

  // Sub-mode: economy on every on-state entry
  wire entering_on = tgt_d.cpu;
  wire fix_d = entering_on ? 1'b0 : w_fix ? 1'b1 : w_eco ? 1'b0 : FIXED_LATENCY;  // R10 R11

  // USB regulator sequencing
  wire reg_on = usb_en_q && VBUS_VALID && !in_off;                       // R03
  wire settled = settle_q == SETTLE_CYC[15:0];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h0;
    end else begin
      wr_pend_q <= acc && HWRITE;
      addr_q    <= HADDR[11:0];
    end
  end

  // Core state registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_ON;
      cause_q <= 32'h0;
      FIXED_LATENCY <= 1'b0;
      vbus_q  <= 1'b0;
      usb_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      FIXED_LATENCY <= fix_d;
      vbus_q  <= VBUS_VALID;
      if (tgt_d.periph) usb_en_q <= 1'b0;
      else if (wr && addr_q == `OFS_USB_ENABLE) usb_en_q <= HWDATA[0];
    end
  end

  // Regulator settle counter and events
  always_ff @(posedge CLK) begin
    if (RESET) begin
      settle_q <= 16'h0;
      rdy_q    <= 1'b0;
      USB_REG_ON <= 1'b0;
      VBUS_DETECTED_EVENT <= 1'b0;
      VBUS_REMOVED_EVENT  <= 1'b0;
      USB_SUPPLY_READY_EVENT <= 1'b0;
    end else begin
      USB_REG_ON <= reg_on;
      settle_q <= !reg_on ? 16'h0 : settled ? settle_q : settle_q + 16'h1;
      rdy_q    <= reg_on && settled;
      VBUS_DETECTED_EVENT <= vbus_rise;                                  // R01
      VBUS_REMOVED_EVENT  <= !VBUS_VALID && vbus_q;                      // R01
      USB_SUPPLY_READY_EVENT <= reg_on && settled && !rdy_q;             // R03
    end
  end

  // Pin selects: cleared only by brownout and power-on, so a pin reset keeps its pin
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_sel0_q <= `PIN_SEL_RESET;
      pin_sel1_q <= `PIN_SEL_RESET;
    end else if (hard) begin
      pin_sel0_q <= `PIN_SEL_RESET;
      pin_sel1_q <= `PIN_SEL_RESET;
    end else if (wr && addr_q == `OFS_PIN_SEL0) begin
      pin_sel0_q <= HWDATA;
    end else if (wr && addr_q == `OFS_PIN_SEL1) begin
      pin_sel1_q <= HWDATA;
    end
  end

  // Per-section RAM power: bit0 power, bit1 hold; access and retention
  genvar g;
  generate
    for (g = 0; g < RAM_SECTIONS; g++) begin : g_ram
      wire sel = wr && is_ram && ram_idx == 4'(g);
      always_ff @(posedge CLK) begin
        if (RESET || tgt_d.retained) ram_pwr_q[g] <= `RAM_PWR_RESET;     // R14
        else if (sel) ram_pwr_q[g] <= HWDATA[1:0];
      end
      always_ff @(posedge CLK) begin
        if (RESET) begin
          RAM_ACCESS[g] <= 1'b0;
          RAM_RETAIN[g] <= 1'b0;
        end else begin
          RAM_ACCESS[g] <= state_d == ST_ON && ram_pwr_q[g][0];          // R12 R13
          RAM_RETAIN[g] <= (state_d == ST_ON && ram_pwr_q[g][0]) || ram_pwr_q[g][1];  // R12 R13
        end
      end
    end
  endgenerate

  // Read mux on the address phase; shows register state as of that edge
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    unique case (rd_addr)
      `OFS_RESET_CAUSE: rd_d = cause_q;
      `OFS_USB_STATUS:  rd_d = {30'h0, rdy_q, VBUS_VALID};
      `OFS_MODE_STATUS: rd_d = {29'h0, FIXED_LATENCY, state_q};
      `OFS_USB_ENABLE:  rd_d = {31'h0, usb_en_q};
      `OFS_PIN_SEL0:    rd_d = pin_sel0_q;
      `OFS_PIN_SEL1:    rd_d = pin_sel1_q;
      default: if (rd_ram && rd_idx < RAM_SECTIONS) rd_d = {30'h0, ram_pwr_q[rd_idx]};
    endcase
  end

  // Outputs; off state holds core unpowered, deep-off write pulses task abort one cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      HRDATA     <= 32'h0;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      RST_OUT    <= '1;
      CORE_POWER_ON <= 1'b1;
      TASK_ABORT <= 1'b0;
    end else begin
      HRDATA     <= (acc && !HWRITE) ? rd_d : 32'h0;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      RST_OUT    <= tgt_d;
      CORE_POWER_ON <= state_d != ST_OFF;                                // R04 R08
      TASK_ABORT <= w_off;                                               // R04
    end
  end

  a_vbus_event: assert property (@(posedge CLK) disable iff (RESET)   // R01
    (VBUS_VALID && !$past(VBUS_VALID)) |=> VBUS_DETECTED_EVENT) else $error("vbus event missing");
  a_off_power: assert property (@(posedge CLK) disable iff (RESET)    // R04
    (w_off && !DEBUG_MODE && !tgt_d.cpu && !hard) |=> !CORE_POWER_ON) else $error("core not off");
  a_emu_off: assert property (@(posedge CLK) disable iff (RESET)      // R08
    (w_off && DEBUG_MODE) |=> CORE_POWER_ON) else $error("emulated off lost power");
  a_wake_reset: assert property (@(posedge CLK) disable iff (RESET)   // R06
    (in_off && any_wake) |=> (RST_OUT.cpu && state_q == ST_ON)) else $error("wake without reset");
  a_soft_gpio: assert property (@(posedge CLK) disable iff (RESET)    // R19
    soft_rst |=> (RST_OUT.gpio && RST_OUT.cpu)) else $error("soft reset targets");
  a_bor_cause: assert property (@(posedge CLK) disable iff (RESET)    // R20
    bor |=> (RST_OUT.cause && cause_q == 32'h0)) else $error("brownout cause");
  a_eco_entry: assert property (@(posedge CLK) disable iff (RESET)    // R09
    tgt_d.cpu |=> !FIXED_LATENCY) else $error("sub-mode not economy");
  a_fix_task: assert property (@(posedge CLK) disable iff (RESET)     // R10
    (w_fix && !tgt_d.cpu) |=> FIXED_LATENCY) else $error("fixed latency not set");
  a_cause_keep: assert property (@(posedge CLK) disable iff (RESET)   // R23
    (cause_q[`CAUSE_PIN] && !w_cause && !hard) |=> cause_q[`CAUSE_PIN]) else $error("cause lost");

  // Further checks, clocked and disabled by the defaults above
  a_rem_event: assert property ( // R01
    (!VBUS_VALID && vbus_q) |=> VBUS_REMOVED_EVENT)
    else $error("vbus removed event missing");
  a_vbus_cause: assert property ( // R02
    (in_off && vbus_rise && !hard) |=> cause_q[`CAUSE_VBUS])
    else $error("vbus wake cause missing");
  a_reg_on: assert property ( // R03
    (usb_en_q && VBUS_VALID && !in_off) |=> USB_REG_ON)
    else $error("usb regulator not on");
  a_rdy_pulse: assert property ( // R03
    USB_SUPPLY_READY_EVENT |=> !USB_SUPPLY_READY_EVENT)
    else $error("ready event repeated");
  a_abort_pulse: assert property ( // R04
    w_off |=> TASK_ABORT)
    else $error("tasks not aborted");
  a_off_stay: assert property ( // R04
    (state_q == ST_OFF && !tgt_d.cpu) |=> !CORE_POWER_ON)
    else $error("core powered in deep-off");
  a_gpio_wake: assert property ( // R05
    (in_off && WAKE.gpio_wake) |=> (state_q == ST_ON))
    else $error("gpio wake ignored");
  a_field_wake: assert property ( // R05
    (in_off && WAKE.field_wake) |=> RST_OUT.cpu)
    else $error("field wake without reset");
  a_fix_hold: assert property ( // R10
    (!w_fix && !w_eco && !tgt_d.cpu) |=> $stable(FIXED_LATENCY))
    else $error("sub-mode changed on its own");
  a_eco_task: assert property ( // R11
    (w_eco && !tgt_d.cpu) |=> !FIXED_LATENCY)
    else $error("economy task ignored");
  a_ram_off: assert property ( // R12
    (state_d != ST_ON) |=> (RAM_ACCESS == '0))
    else $error("ram accessible in deep-off");
  a_ram_on: assert property ( // R13
    (state_d == ST_ON && ram_pwr_q[0][0]) |=> (RAM_ACCESS[0] && RAM_RETAIN[0]))
    else $error("powered ram section not usable");
  a_ram_keep: assert property ( // R14
    (in_off && !wr && !tgt_d.retained) |=> $stable(ram_pwr_q[0]))
    else $error("ram power setting lost");
  a_por_hold: assert property ( // R15
    por |=> (RST_OUT == '1))
    else $error("power-on not holding reset");
  a_pin_reset: assert property ( // R16
    (pin_rst && !hard) |=> (RST_OUT.retained && cause_q[`CAUSE_PIN]))
    else $error("pin reset missing");
  a_soft_cause: assert property ( // R17
    (soft_rst && !hard) |=> cause_q[`CAUSE_SOFT])
    else $error("soft reset cause missing");
  a_bor_swd: assert property ( // R18
    bor |=> (RST_OUT.swd_port && RST_OUT.cpu))
    else $error("brownout targets missing");
  a_wake_gpio: assert property ( // R19
    (any_wake && !hard && !full && !soft_rst) |=> !RST_OUT.gpio)
    else $error("wake reset gpio");
  a_emu_dap: assert property ( // R19
    (any_wake && DEBUG_MODE && !hard && !full) |=> !RST_OUT.debug)
    else $error("debug reset in debug mode wake");
  a_lock_dbg: assert property ( // R19
    (CORE_LOCKUP && DEBUG_MODE && !in_off && !tgt_d.gpio) |=> !RST_OUT.cpu)
    else $error("lockup reset in debug mode");
  a_wdog_reset: assert property ( // R22
    wdog_rst |=> (RST_OUT.wdog && RST_OUT.retained))
    else $error("watchdog reset targets missing");
  c_wake_vbus: cover property (@(posedge CLK) in_off && vbus_rise);
  c_usb_ready: cover property (@(posedge CLK) USB_SUPPLY_READY_EVENT);
  c_emu_off:   cover property (@(posedge CLK) state_q == ST_EMU_OFF);
  c_pin_reset: cover property (pin_rst);
  c_dbg_wake:  cover property (any_wake && DEBUG_MODE);

endmodule // power_mode_reset_manager

// *** verif/far_side_model.sv ***
// Purpose: Far side model: wake sources and a memory transfer engine
// Assumes: Requests come from the bench, synchronous to clk
// Notes:   Transfer length is chosen by the bench, so waits vary
`timescale 1ns/1ps
module far_side_model
  import pwr_mgr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire wake_sigs_t wake_req,
  input  wire logic       xfer_go,
  input  wire logic [3:0] xfer_len,
  output wake_sigs_t      wake,
  output logic            xfer_busy
);
  wake_sigs_t wake_q;
  logic [3:0] left_q;
  logic [3:0] left_d;

  // Wake levels pass a flop, as a real source's output would
  always_ff @(posedge clk) begin
    wake_q <= rst ? '0 : wake_req;
  end
  assign wake = wake_q;

  // Transfer counts down; software must see it idle before deep-off
  assign left_d = xfer_go ? xfer_len : (left_q - {3'h0, |left_q});
  always_ff @(posedge clk) begin
    left_q <= rst ? 4'h0 : left_d;
  end
  assign xfer_busy = |left_q;
endmodule // far_side_model

// *** verif/tb_power_mode_reset_manager.sv ***
// Purpose: Self-checking bench for the power mode and reset manager
// Assumes: Zero-wait AHB-Lite slave, settle count shortened to 4
// Notes:   Results are sampled one edge late, so launch updates have landed
`timescale 1ns/1ps
`include "pwr_mgr_params.svh"
module tb_power_mode_reset_manager
  import pwr_mgr_pkg::*;
;
  localparam int SETTLE = 4;
  logic         clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
  logic         vbus = 1'b0, sup_ok = 1'b1, regs_st = 1'b1, bo = 1'b0, pin_n = 1'b1;
  logic         core_req = 1'b0, dbg_rst = 1'b0, lockup = 1'b0, wdog = 1'b0;
  logic         dbg_mode = 1'b0, xfer_go = 1'b0;
  logic [1:0]   htrans = 2'b00;
  logic [3:0]   xfer_len = 4'h0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [31:0]  rng = 32'h0001_23c6; // Seed 74694
  logic         hrdy, hresp, pwr_on, abort, fixlat, usb_on, e_det, e_rem, e_rdy, busy;
  logic [8:0]   ram_acc, ram_ret;
  logic [1:0]   cfg [9];
  wake_sigs_t   wreq = '0, wake;
  rst_targets_t rst_out, seen;
  int           bad_count = 0, compares = 0, n_det = 0, n_rem = 0, n_rdy = 0, n_abt = 0, i;

  always #12.5 clk = ~clk;

  power_mode_reset_manager #(.RAM_SECTIONS(9), .SETTLE_CYC(SETTLE)) u_dut (
    .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .VBUS_VALID(vbus), .SUPPLY_OK(sup_ok),
    .REGS_STARTED(regs_st), .BROWNOUT(bo), .RESET_PIN_N(pin_n), .CORE_RESET_REQ(core_req),
    .DEBUG_PORT_RESET(dbg_rst), .CORE_LOCKUP(lockup), .WATCHDOG_TIMEOUT(wdog),
    .DEBUG_MODE(dbg_mode), .WAKE(wake), .RST_OUT(rst_out), .CORE_POWER_ON(pwr_on),
    .TASK_ABORT(abort), .FIXED_LATENCY(fixlat), .USB_REG_ON(usb_on),
    .VBUS_DETECTED_EVENT(e_det), .VBUS_REMOVED_EVENT(e_rem),
    .USB_SUPPLY_READY_EVENT(e_rdy), .RAM_ACCESS(ram_acc), .RAM_RETAIN(ram_ret));

  far_side_model u_far (.clk(clk), .rst(reset), .wake_req(wreq), .xfer_go(xfer_go),
    .xfer_len(xfer_len), .wake(wake), .xfer_busy(busy));

  // Sticky reset targets and pulse counts, so short pulses are never missed
  always @(posedge clk) begin
    seen <= clr ? '0 : (seen | rst_out);
    n_det <= n_det + int'(e_det);
    n_rem <= n_rem + int'(e_rem);
    n_rdy <= n_rdy + int'(e_rdy);
    n_abt <= n_abt + int'(abort);
  end

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Soft and lockup, watchdog and pin, then supply faults
  function automatic logic [8:0] exp_rst(input int s);
    return (s < 3) ? 9'h1c0 : ((s < 5) ? 9'h1ee : 9'h1ff);
  endfunction

  function automatic logic [31:0] exp_cause(input int s);
    int b;
    b = (s < 2) ? `CAUSE_SOFT : (s == 2) ? `CAUSE_LOCKUP : (s == 3) ? `CAUSE_WDOG : `CAUSE_PIN;
    return (s < 5) ? (32'h1 << b) : 32'h0;
  endfunction

  function automatic logic [8:0] exp_ram(input logic off, input logic ret);
    logic [8:0] v;
    for (int n = 0; n < 9; n++)
      v[n] = off ? (ret & cfg[n][1]) : (ret ? (|cfg[n]) : cfg[n][0]);
    return v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic arm();
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
  endtask

  task automatic drive(input int s, input logic v);
    case (s)
      0: core_req <= v;
      1: dbg_rst <= v;
      2: lockup <= v;
      3: wdog <= v;
      4: pin_n <= !v;
      5: bo <= v;
      6: sup_ok <= !v;
      default: regs_st <= !v;
    endcase
  endtask

  // A transfer of random length is drained before deep-off is asked for
  task automatic deep_off();
    xfer_go <= 1'b1;
    xfer_len <= 4'(rnd());
    cyc(1);
    xfer_go <= 1'b0;
    cyc(1);
    while (busy === 1'b1) cyc(1);
    ahb(1'b1, `OFS_DEEP_OFF, 32'h1);
    cyc(4);
  endtask

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under 3000 cycles
  initial begin
    cyc(5000);
    bad_count++;
    print_verdict();
  end

  initial begin
    cyc(5);
    reset <= 1'b0;
    rdchk("mode", `OFS_MODE_STATUS, 32'h0);
    rdchk("ram0", `OFS_RAM_BASE, 32'h1);
    chk("access", 32'h1ff, {23'h0, ram_acc});
    rdchk("pinsel", `OFS_PIN_SEL0, `PIN_SEL_RESET);
    arm();
    pin_n <= 1'b0;
    cyc(3);
    pin_n <= 1'b1;
    cyc(3);
    chk("rst_pin_off", 32'h0, {23'h0, seen});
    ahb(1'b1, `OFS_TASK_FIXLAT, 32'h1);
    cyc(2);
    chk("fixlat", 32'h1, {31'h0, fixlat});
    rdchk("mode", `OFS_MODE_STATUS, 32'h4);
    ahb(1'b1, `OFS_TASK_ECONOMY, 32'h1);
    cyc(2);
    chk("fixlat", 32'h0, {31'h0, fixlat});
    vbus <= 1'b1;
    cyc(5);
    chk("det", 32'h1, n_det);
    ahb(1'b1, `OFS_USB_ENABLE, 32'h1);
    cyc(2);
    chk("usb_on", 32'h1, {31'h0, usb_on});
    chk("rdy", 32'h0, n_rdy);
    cyc(SETTLE + 4);
    chk("rdy", 32'h1, n_rdy);
    rdchk("usbstat", `OFS_USB_STATUS, 32'h3);
    vbus <= 1'b0;
    cyc(5);
    chk("rem", 32'h1, n_rem);
    // Every reset source; the pin flag is left set for brownout to clear
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        ahb(1'b1, `OFS_PIN_SEL0, 32'h0);
        ahb(1'b1, `OFS_PIN_SEL1, 32'h0);
      end
      arm();
      drive(i, 1'b1);
      cyc(3);
      drive(i, 1'b0);
      cyc(3);
      chk("rst", {23'h0, exp_rst(i)}, {23'h0, seen});
      rdchk("cause", `OFS_RESET_CAUSE, exp_cause(i));
      if (i != 4) ahb(1'b1, `OFS_RESET_CAUSE, 32'hffff_ffff);
    end
    // Random power and hold settings per RAM section
    for (i = 0; i < 9; i++) begin
      cfg[i] = 2'(rnd());
      ahb(1'b1, `OFS_RAM_BASE + 12'(i * 16), {30'h0, cfg[i]});
    end
    cyc(2);
    chk("access", {23'h0, exp_ram(1'b0, 1'b0)}, {23'h0, ram_acc});
    chk("retain", {23'h0, exp_ram(1'b0, 1'b1)}, {23'h0, ram_ret});
    for (i = 0; i < 4; i++) begin
      ahb(1'b1, `OFS_TASK_FIXLAT, 32'h1);
      deep_off();
      chk("power", 32'h0, {31'h0, pwr_on});
      chk("abort", i + 1, n_abt);
      chk("access", 32'h0, {23'h0, ram_acc});
      chk("retain", {23'h0, exp_ram(1'b1, 1'b1)}, {23'h0, ram_ret});
      arm();
      if (i < 3) wreq <= wake_sigs_t'(3'(3'b100 >> i));
      else vbus <= 1'b1;
      cyc(4);
      wreq <= '0;
      vbus <= 1'b0;
      cyc(4);
      chk("rst_wake", 32'h1ac, {23'h0, seen});
      chk("power", 32'h1, {31'h0, pwr_on});
      chk("fixlat", 32'h0, {31'h0, fixlat});
      rdchk("cause", `OFS_RESET_CAUSE, 32'h1 << ((i == 0) ? `CAUSE_GPIO : (i == 1) ?
        `CAUSE_COMP : (i == 2) ? `CAUSE_FIELD : `CAUSE_VBUS));
      ahb(1'b1, `OFS_RESET_CAUSE, 32'hffff_ffff);
    end
    for (i = 0; i < 9; i++) rdchk("ramreg", `OFS_RAM_BASE + 12'(i * 16), {30'h0, cfg[i]});
    // Debug mode keeps the core powered and the debug targets out of reset
    dbg_mode <= 1'b1;
    deep_off();
    rdchk("mode", `OFS_MODE_STATUS, 32'h3);
    chk("power", 32'h1, {31'h0, pwr_on});
    arm();
    wreq <= 3'b100;
    cyc(4);
    wreq <= '0;
    cyc(4);
    chk("rst_dbg", 32'h18c, {23'h0, seen});
    dbg_mode <= 1'b0;
    ahb(1'b1, 12'h7f0, 32'hffff_ffff);
    rdchk("unmapped", 12'h7f0, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    print_verdict();
  end
endmodule // tb_power_mode_reset_manager
